//--- verilog/ace_pkg.sv
// Shared constants, types and helpers of the serial avionics channel engine.
`default_nettype none
package ace_pkg;

	// ==========================================================
	// Timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int HI_BIT_NS = 10000;
	localparam int LO_BIT_NS = 80000;
	localparam int TICK_NS = 100000;
	localparam int HI_BIT_CYC = HI_BIT_NS / CLK_PERIOD_NS;
	localparam int LO_BIT_CYC = LO_BIT_NS / CLK_PERIOD_NS;
	localparam int TICK_CYC = TICK_NS / CLK_PERIOD_NS;
	// A marking pulse shorter than one fast bit period can only be fast traffic.
	localparam int SPD_THR_CYC = HI_BIT_CYC;
	localparam int GAP_BITS = 4;
	localparam int WORD_BITS = 32;

	// ==========================================================
	// Register offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_RXDATA = 8'h08;
	localparam logic [7:0] REG_TXAPER = 8'h0C;
	localparam logic [7:0] REG_RATE = 8'h10;
	localparam logic [7:0] REG_FILT = 8'h14;
	localparam logic [7:0] REG_SLOT_BASE = 8'h18;
	localparam int SLOT_STRIDE = 8;
	localparam int SLOT_PER_OFS = 4;

	// ==========================================================
	// Fields and reset values
	localparam int CTRL_TX = 0;
	localparam int CTRL_HS = 1;
	localparam int CTRL_CUST = 2;
	localparam int CTRL_FILT = 3;
	localparam int CTRL_LEGA = 4;
	localparam int CTRL_LEGB = 6;
	localparam int CTRL_EN = 8;
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam logic [1:0] LEG_OPEN = 2'h1;
	localparam logic [1:0] LEG_GND = 2'h2;
	localparam int ST_RXV = 0;
	localparam int ST_RXHS = 1;
	localparam int ST_PERR = 2;
	localparam int ST_OVR = 3;
	localparam int ST_TXBUSY = 4;
	localparam int ST_APEND = 5;
	localparam int FILT_LBL_LSB = 0;
	localparam int FILT_SDI_LSB = 8;
	localparam int WORD_SDI_LSB = 8;

	typedef enum logic [1:0] {TX_IDLE, TX_MARK, TX_SPACE, TX_GAP} ace_tx_t;

	// Parity bit that makes a 32-bit word odd.
	function automatic logic oddPar(input logic [30:0] d);
		return ~^d;
	endfunction

endpackage
`default_nettype wire

//--- verilog/ace_lbl_mem.sv
// Per-label acceptance table with registered read data.
`timescale 1ns/1ps
`default_nettype none
module ace_lbl_mem #(
	parameter int WIDTH = 4,
	parameter int ABITS = 8
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset_n,
	// Write port
	input wire logic wrEn,
	input wire logic [ABITS-1:0] wrAddr,
	input wire logic [WIDTH-1:0] wrData,
	// Read port
	input wire logic [ABITS-1:0] rdAddr,
	output logic [WIDTH-1:0] rdData
);
	// The array has no reset; software loads it before enabling filtering.
	logic [WIDTH-1:0] mem [2**ABITS];

	always_ff @(posedge clk_sys) begin
		if (wrEn) begin
			mem[wrAddr] <= wrData;
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			rdData <= '0;
		end else begin
			rdData <= mem[rdAddr];
		end
	end
endmodule
`default_nettype wire

//--- verilog/ace_channel.sv
// One serial avionics channel: receiver or scheduled transmitter behind APB.
// ==========================================================
// Notes on behaviour
// (RQ1) Each channel is set by software as either receiver or transmitter.
// (RQ2) The receiver finds the line speed itself from pulse widths.
// (RQ3) Received words pass a per-channel label and SDI acceptance table.
// (RQ4) Periodic slots fire on their own timers at the programmed repetition rate.
// (RQ5) Aperiodic words go only into idle time, after any pending periodic slot; a slot falling due while one is sent waits until it ends.
// (RQ6) Receive and transmit choose 12.5 or 100 kbit/s independently.
// (RQ7) Software may program a custom bit period per channel.
// (RQ8) Software may leave either output leg open; legOpen follows it only while CTRL_TX is set.
// (RQ9) Software may force either output leg to ground; legGnd follows it only while CTRL_TX is set.
// (RQ10) Software keeps the null level between high and low levels.
// (RQ11) Words are 32 bits, label first, odd parity in the last bit.
`timescale 1ns/1ps
`default_nettype none
module ace_channel #(
	parameter int LO_BIT_CYC_P = ace_pkg::LO_BIT_CYC,
	parameter int TICK_CYC_P = ace_pkg::TICK_CYC,
	parameter int NSLOT = 2
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset_n,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Line receiver
	input wire logic rxHi,
	input wire logic rxLo,
	// Line driver
	output logic txHi,
	output logic txLo,
	output logic [1:0] legOpen,
	output logic [1:0] legGnd
);
	import ace_pkg::*;

	// ==========================================================
	// State
	typedef struct packed {
		logic [8:0] ctrl;
		logic [15:0] rate;
		logic [NSLOT-1:0][31:0] pword;
		logic [NSLOT-1:0][15:0] pper;
		logic [NSLOT-1:0][15:0] ptmr;
		logic [NSLOT-1:0] ppend;
		logic [15:0] tick;
		logic [31:0] aword;
		logic apend;
		ace_tx_t txSt;
		logic [31:0] txSh;
		logic [4:0] txBit;
		logic [17:0] txCnt;
		logic txHi;
		logic txLo;
		logic [1:0] legOpen;
		logic [1:0] legGnd;
		logic rxAct;
		logic [31:0] rxSh;
		logic [4:0] rxBits;
		logic [15:0] rxW;
		logic [17:0] rxNull;
		logic rxHs;
		logic [1:0] rxStg;
		logic [31:0] rxCand;
		logic [31:0] rxData;
		logic rxValid;
		logic rxPerr;
		logic rxOvr;
		logic [31:0] prdata;
	} ace_state_t;

	ace_state_t q;
	ace_state_t d;
	logic wrAcc;
	logic rdAcc;
	logic tickNow;
	logic txOn;
	logic rxOn;
	logic [17:0] txBitCyc;
	logic [17:0] txHalf;
	logic [17:0] rxBitCyc;
	logic [3:0] memQ;

	function automatic logic [7:0] slotAddr(input int i, input int k);
		return 8'(int'(REG_SLOT_BASE) + SLOT_STRIDE * i + SLOT_PER_OFS * k);
	endfunction

	function automatic logic isMapped(input logic [7:0] a);
		logic m;
		m = (a == REG_CTRL) || (a == REG_STATUS) || (a == REG_RXDATA) || (a == REG_TXAPER)
			|| (a == REG_RATE) || (a == REG_FILT);
		for (int i = 0; i < NSLOT; i++) begin
			m = m || (a == slotAddr(i, 0)) || (a == slotAddr(i, 1));
		end
		return m;
	endfunction

	function automatic logic [31:0] readMux(input logic [7:0] a);
		logic [31:0] r;
		r = '0;
		case (a)
			REG_CTRL: r[8:0] = q.ctrl;
			REG_STATUS: begin
				r[ST_RXV] = q.rxValid;
				r[ST_RXHS] = q.rxHs;
				r[ST_PERR] = q.rxPerr;
				r[ST_OVR] = q.rxOvr;
				r[ST_TXBUSY] = (q.txSt != TX_IDLE);
				r[ST_APEND] = q.apend;
			end
			REG_RXDATA: r = q.rxData;
			REG_TXAPER: r = q.aword;
			REG_RATE: r[15:0] = q.rate;
			default: r = '0;
		endcase
		for (int i = 0; i < NSLOT; i++) begin
			if (a == slotAddr(i, 0)) begin
				r = q.pword[i];
			end
			if (a == slotAddr(i, 1)) begin
				r = {16'h0000, q.pper[i]};
			end
		end
		return r;
	endfunction

	// ==========================================================
	// Bus and rate selection
	assign wrAcc = psel && penable && pwrite;
	assign rdAcc = psel && penable && !pwrite;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !isMapped(paddr);
	assign txOn = q.ctrl[CTRL_EN] && q.ctrl[CTRL_TX]; // RQ1
	assign rxOn = q.ctrl[CTRL_EN] && !q.ctrl[CTRL_TX]; // RQ1
	assign tickNow = (q.tick == 16'(TICK_CYC_P - 1));
	// A custom period below two cycles is not supported.
	assign txBitCyc = q.ctrl[CTRL_CUST] ? {2'b00, q.rate} : // RQ7
		(q.ctrl[CTRL_HS] ? 18'(HI_BIT_CYC) : 18'(LO_BIT_CYC_P)); // RQ6
	assign txHalf = {1'b0, txBitCyc[17:1]};
	assign rxBitCyc = q.ctrl[CTRL_CUST] ? {2'b00, q.rate} : // RQ7
		(q.rxHs ? 18'(HI_BIT_CYC) : 18'(LO_BIT_CYC_P)); // RQ2

	ace_lbl_mem #(.WIDTH(4), .ABITS(8)) i_ace_lbl_mem (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.wrEn(wrAcc && (paddr == REG_FILT)),
		.wrAddr(pwdata[FILT_LBL_LSB +: 8]),
		.wrData(pwdata[FILT_SDI_LSB +: 4]),
		.rdAddr(q.rxCand[7:0]),
		.rdData(memQ)
	);

	// ==========================================================
	// Next state
	always_comb begin
		logic [31:0] w;
		logic ld;
		logic act;
		int pick;
		w = '0;
		ld = 1'b0;
		pick = 0;
		act = rxHi || rxLo;
		d = q;
		if (psel && !penable) begin
			d.prdata = readMux(paddr);
		end
		if (wrAcc && (paddr == REG_STATUS)) begin
			d.rxPerr = q.rxPerr && !pwdata[ST_PERR];
			d.rxOvr = q.rxOvr && !pwdata[ST_OVR];
		end
		if (rdAcc && (paddr == REG_RXDATA)) begin
			d.rxValid = 1'b0;
		end
		// Slot timers run off a free tick, so inserted words cannot move them.
		d.tick = tickNow ? 16'h0000 : q.tick + 16'h0001;
		for (int i = 0; i < NSLOT; i++) begin
			if (txOn && tickNow && (q.pper[i] != 16'h0000)) begin
				if (q.ptmr[i] == 16'h0000) begin
					d.ppend[i] = 1'b1; // RQ4
					d.ptmr[i] = q.pper[i] - 16'h0001; // RQ4
				end else begin
					d.ptmr[i] = q.ptmr[i] - 16'h0001;
				end
			end
		end
		unique case (q.txSt)
			TX_IDLE: begin
				for (int i = NSLOT - 1; i >= 0; i--) begin
					if (q.ppend[i]) begin
						pick = i;
					end
				end
				if (txOn && (|q.ppend)) begin
					w = q.pword[pick];
					d.ppend[pick] = tickNow && (q.ptmr[pick] == 16'h0000) && (q.pper[pick] != 16'h0000);
					ld = 1'b1;
				end else if (txOn && q.apend) begin
					w = q.aword; // RQ5
					d.apend = 1'b0;
					ld = 1'b1;
				end
			end
			TX_MARK: begin
				if (q.txCnt == txHalf - 18'h0_0001) begin
					d.txSt = TX_SPACE;
					d.txCnt = '0;
					d.txHi = 1'b0;
					d.txLo = 1'b0;
				end else begin
					d.txCnt = q.txCnt + 18'h0_0001;
				end
			end
			TX_SPACE: begin
				if (q.txCnt == txBitCyc - txHalf - 18'h0_0001) begin
					d.txCnt = '0;
					if (q.txBit == 5'h1F) begin
						d.txSt = TX_GAP;
					end else begin
						d.txBit = q.txBit + 5'h01;
						d.txSh = {1'b0, q.txSh[31:1]};
						d.txSt = TX_MARK;
						d.txHi = q.txSh[1];
						d.txLo = !q.txSh[1];
					end
				end else begin
					d.txCnt = q.txCnt + 18'h0_0001;
				end
			end
			TX_GAP: begin
				if (q.txCnt == 18'(GAP_BITS * int'(txBitCyc)) - 18'h0_0001) begin
					d.txSt = TX_IDLE;
				end else begin
					d.txCnt = q.txCnt + 18'h0_0001;
				end
			end
		endcase
		if (ld) begin
			d.txSh = {oddPar(w[30:0]), w[30:0]}; // RQ11
			d.txBit = '0;
			d.txCnt = '0;
			d.txSt = TX_MARK;
			d.txHi = w[0]; // RQ11
			d.txLo = !w[0];
		end
		if (!txOn) begin
			d.txSt = TX_IDLE; // RQ1
			d.txHi = 1'b0;
			d.txLo = 1'b0;
		end
		d.legOpen = {q.ctrl[CTRL_LEGB +: 2] == LEG_OPEN, q.ctrl[CTRL_LEGA +: 2] == LEG_OPEN}
			& {2{q.ctrl[CTRL_TX]}}; // RQ8
		d.legGnd = {q.ctrl[CTRL_LEGB +: 2] == LEG_GND, q.ctrl[CTRL_LEGA +: 2] == LEG_GND}
			& {2{q.ctrl[CTRL_TX]}}; // RQ9
		d.rxAct = act;
		d.rxStg = {q.rxStg[0], 1'b0};
		if (!rxOn) begin
			d.rxBits = '0;
			d.rxStg = '0;
		end else if (act && !q.rxAct) begin
			d.rxSh = {rxHi, q.rxSh[31:1]}; // RQ11
			d.rxW = '0;
			d.rxNull = '0;
			if (q.rxBits == 5'h1F) begin
				d.rxBits = '0;
				d.rxCand = {rxHi, q.rxSh[31:1]};
				d.rxStg[0] = 1'b1;
			end else begin
				d.rxBits = q.rxBits + 5'h01;
			end
		end else if (act) begin
			if (q.rxW != 16'hFFFF) begin
				d.rxW = q.rxW + 16'h0001;
			end
		end else begin
			if (q.rxAct) begin
				d.rxHs = (q.rxW < 16'(SPD_THR_CYC)); // RQ2
			end
			// A null longer than two bit periods ends any partial word.
			if (q.rxNull >= {rxBitCyc[16:0], 1'b0}) begin
				d.rxBits = '0;
			end else begin
				d.rxNull = q.rxNull + 18'h0_0001;
			end
		end
		if (q.rxStg[1] && (!q.ctrl[CTRL_FILT] || memQ[q.rxCand[WORD_SDI_LSB +: 2]])) begin // RQ3
			d.rxData = q.rxCand;
			d.rxPerr = d.rxPerr || !(^q.rxCand); // RQ11
			d.rxOvr = d.rxOvr || (q.rxValid && !(rdAcc && (paddr == REG_RXDATA)));
			d.rxValid = 1'b1;
		end
		if (wrAcc) begin
			case (paddr)
				REG_CTRL: d.ctrl = pwdata[8:0]; // RQ1
				REG_RATE: d.rate = pwdata[15:0]; // RQ7
				REG_TXAPER: begin
					d.aword = pwdata; // RQ5
					d.apend = 1'b1;
				end
				default: d.ctrl = d.ctrl;
			endcase
			for (int i = 0; i < NSLOT; i++) begin
				if (paddr == slotAddr(i, 0)) begin
					d.pword[i] = pwdata;
				end
				if (paddr == slotAddr(i, 1)) begin
					d.pper[i] = pwdata[15:0]; // RQ4
					d.ptmr[i] = '0;
				end
			end
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			q <= '0;
			q.ctrl <= CTRL_RST[8:0];
		end else begin
			q <= d;
		end
	end

	assign prdata = q.prdata;
	assign txHi = q.txHi;
	assign txLo = q.txLo;
	assign legOpen = q.legOpen;
	assign legGnd = q.legGnd;

	// ==========================================================
	// Checks
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!reset_n);

	sequence s_wrCtrl;
		wrAcc && (paddr == REG_CTRL) && pwdata[CTRL_TX];
	endsequence
	sequence s_load;
		(q.txSt == TX_IDLE) ##1 (q.txSt == TX_MARK);
	endsequence

	property p_rxSilent;
		!q.ctrl[CTRL_TX] [*2] |-> !txHi && !txLo;
	endproperty
	a_rxSilent: assert property (p_rxSilent) else $error("Driver active in receive mode."); // RQ1
	property p_speedDet;
		rxOn && q.rxAct && !(rxHi || rxLo) && (q.rxW < 16'(SPD_THR_CYC)) |=> q.rxHs;
	endproperty
	a_speedDet: assert property (p_speedDet) else $error("Short pulse not taken as fast."); // RQ2
	property p_filtDrop;
		q.rxStg[1] && q.ctrl[CTRL_FILT] && !memQ[q.rxCand[WORD_SDI_LSB +: 2]] |=> $stable(q.rxData);
	endproperty
	a_filtDrop: assert property (p_filtDrop) else $error("Rejected word was stored."); // RQ3
	property p_slotFire;
		txOn && tickNow && (q.ptmr[0] == 16'h0000) && (q.pper[0] != 16'h0000) |=> q.ppend[0] || (q.txSt == TX_MARK);
	endproperty
	a_slotFire: assert property (p_slotFire) else $error("Slot timer expiry lost."); // RQ4
	property p_perFirst;
		txOn && (q.txSt == TX_IDLE) && (|q.ppend) && q.apend |=> q.apend;
	endproperty
	a_perFirst: assert property (p_perFirst) else $error("Aperiodic word overtook a due slot."); // RQ5
	property p_hiRate;
		q.ctrl[CTRL_HS] && !q.ctrl[CTRL_CUST] |-> txBitCyc == 18'(HI_BIT_CYC);
	endproperty
	a_hiRate: assert property (p_hiRate) else $error("Fast rate not selected."); // RQ6
	property p_custRate;
		q.ctrl[CTRL_CUST] |-> (txBitCyc == {2'b00, q.rate}) && (rxBitCyc == {2'b00, q.rate});
	endproperty
	a_custRate: assert property (p_custRate) else $error("Custom period not used."); // RQ7
	property p_legOpen;
		s_wrCtrl and (pwdata[CTRL_LEGB +: 2] == LEG_OPEN) |=> ##1 legOpen[1] && !legGnd[1];
	endproperty
	a_legOpen: assert property (p_legOpen) else $error("Leg B not opened."); // RQ8
	property p_legGnd;
		s_wrCtrl and (pwdata[CTRL_LEGA +: 2] == LEG_GND) |=> ##1 legGnd[0] && !legOpen[0];
	endproperty
	a_legGnd: assert property (p_legGnd) else $error("Leg A not grounded."); // RQ9
	property p_oddWord;
		s_load |-> (^q.txSh) && !(txHi && txLo);
	endproperty
	a_oddWord: assert property (p_oddWord) else $error("Loaded word has even parity."); // RQ11
endmodule
`default_nettype wire

//--- dv/ace_line_model.sv
// Behavioural far-side equipment: drives the receive lines and captures transmitted words.
`timescale 1ns/1ps
`default_nettype none
module ace_line_model (
	// Clock
	input wire logic clk_sys,
	// Lines into the channel receiver
	output logic rxHi,
	output logic rxLo,
	// Lines from the channel driver
	input wire logic txHi,
	input wire logic txLo
);
	logic actQ;
	logic [31:0] shiftQ;
	logic [5:0] bitCnt;
	logic [31:0] cyc;
	logic [31:0] runCyc;
	logic [31:0] firstCyc;
	logic [31:0] capWord;
	logic [31:0] capStart;
	logic [31:0] capCount;
	logic [31:0] pulseW;

	initial begin
		rxHi = 1'b0;
		rxLo = 1'b0;
		actQ = 1'b0;
		shiftQ = 32'h0000_0000;
		bitCnt = 6'h00;
		cyc = 32'h0000_0000;
		runCyc = 32'h0000_0000;
		firstCyc = 32'h0000_0000;
		capWord = 32'h0000_0000;
		capStart = 32'h0000_0000;
		capCount = 32'h0000_0000;
		pulseW = 32'h0000_0000;
	end

	// ==========================================================
	// Sender
	// Bit 0 goes first; each bit is half a period active, then half null.
	task automatic sendWord(input logic [31:0] w, input int half);
		for (int i = 0; i < 32; i++) begin
			rxHi <= w[i];
			rxLo <= ~w[i];
			repeat (half) @(posedge clk_sys);
			// Null is both legs idle, which sits between the one and zero levels.
			rxHi <= 1'b0;
			rxLo <= 1'b0;
			repeat (half) @(posedge clk_sys);
		end
	endtask

	// ==========================================================
	// Capture
	// Counting bits by null-to-active edges means a lost edge shifts every later word.
	always @(posedge clk_sys) begin
		cyc <= cyc + 32'd1;
		actQ <= txHi | txLo;
		if ((txHi | txLo) && !actQ) begin
			shiftQ <= {txHi, shiftQ[31:1]};
			bitCnt <= (bitCnt == 6'd31) ? 6'd0 : bitCnt + 6'd1;
			runCyc <= 32'd1;
			if (bitCnt == 6'd0) begin
				firstCyc <= cyc;
			end
			if (bitCnt == 6'd31) begin
				capWord <= {txHi, shiftQ[31:1]};
				capStart <= firstCyc;
				capCount <= capCount + 32'd1;
			end
		end else if (txHi | txLo) begin
			runCyc <= runCyc + 32'd1;
		end else if (actQ) begin
			pulseW <= runCyc;
		end
	end
endmodule
`default_nettype wire

//--- dv/ace_channel_tb.sv
// Self-checking testbench of one serial avionics channel driven over APB.
`timescale 1ns/1ps
`default_nettype none
module ace_channel_tb;
	import ace_pkg::*;
	localparam int TB_LO = 80;
	localparam int TB_TICK = 500;
	logic clk_sys;
	logic reset_n;
	logic psel;
	logic penable;
	logic pwrite;
	logic [7:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic rxHi;
	logic rxLo;
	logic txHi;
	logic txLo;
	logic [1:0] legOpen;
	logic [1:0] legGnd;
	int fail_count;
	int check_count;
	int cycles;
	logic [31:0] rdv;
	logic err;
	logic [31:0] w;
	logic [31:0] t0;
	logic [31:0] t1;
	logic [31:0] wRx;

	ace_channel #(.LO_BIT_CYC_P(TB_LO), .TICK_CYC_P(TB_TICK), .NSLOT(2)) i_ace_channel (
		.clk_sys(clk_sys), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.rxHi(rxHi), .rxLo(rxLo), .txHi(txHi), .txLo(txLo), .legOpen(legOpen), .legGnd(legGnd));
	ace_line_model i_ace_line_model (.clk_sys(clk_sys), .rxHi(rxHi), .rxLo(rxLo), .txHi(txHi), .txLo(txLo));

	initial clk_sys = 1'b0;
	always #5 clk_sys = ~clk_sys;

	// ==========================================================
	// Helpers
	function automatic logic [31:0] par(input logic [31:0] v);
		return {~^v[30:0], v[30:0]};
	endfunction

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			$display("FAIL %s expected %h seen %h", n, e, g);
			fail_count++;
		end
	endtask

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do @(posedge clk_sys); while (pready !== 1'b1);
		rdv = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rdm(input string n, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		apb(1'b0, a, 32'h0000_0000);
		chk(n, e & m, rdv & m);
	endtask

	// The capture counter moves in the same update as the word, so wait one edge more.
	task automatic waitWord(output logic [31:0] wd, output logic [31:0] st);
		logic [31:0] n;
		n = i_ace_line_model.capCount;
		wait (i_ace_line_model.capCount != n);
		@(posedge clk_sys);
		wd = i_ace_line_model.capWord;
		st = i_ace_line_model.capStart;
	endtask

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			fail_count++;
			$display("FAIL timeout expected done seen running");
			wrap_up();
		end
	end

	// ==========================================================
	// Tests
	initial begin
		reset_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		fail_count = 0;
		check_count = 0;
		cycles = 0;
		repeat (10) @(posedge clk_sys);
		reset_n <= 1'b1;
		rdm("ctrl reset", REG_CTRL, 32'hFFFF_FFFF, CTRL_RST);
		apb(1'b0, 8'hFC, 32'h0000_0000);
		chk("unmapped read err", 32'h0000_0001, {31'h0, err});
		chk("unmapped read data", 32'h0000_0000, rdv);
		apb(1'b1, 8'hFC, 32'hFFFF_FFFF);
		chk("unmapped write err", 32'h0000_0001, {31'h0, err});
		$display("test registers done");
		apb(1'b1, REG_FILT, 32'h0000_025A);
		apb(1'b1, REG_CTRL, 32'h0000_0108);
		rdm("filter reads zero", REG_FILT, 32'hFFFF_FFFF, 32'h0000_0000);
		wRx = par(32'h0ABC_2D5A);
		i_ace_line_model.sendWord(wRx, 20);
		rdm("rx valid fast", REG_STATUS, 32'h0000_000F, 32'h0000_0003);
		rdm("rx word", REG_RXDATA, 32'hFFFF_FFFF, wRx);
		rdm("valid cleared", REG_STATUS, 32'h0000_0001, 32'h0000_0000);
		i_ace_line_model.sendWord(par(32'h0ABC_2E5A), 20);
		rdm("sdi rejected", REG_STATUS, 32'h0000_0001, 32'h0000_0000);
		i_ace_line_model.sendWord(wRx ^ 32'h8000_0000, 20);
		rdm("parity flag", REG_STATUS, 32'h0000_000D, 32'h0000_0005);
		i_ace_line_model.sendWord(wRx, 20);
		rdm("overrun", REG_STATUS, 32'h0000_000D, 32'h0000_000D);
		apb(1'b1, REG_STATUS, 32'h0000_000C);
		rdm("flags cleared", REG_STATUS, 32'h0000_000C, 32'h0000_0000);
		rdm("last word", REG_RXDATA, 32'hFFFF_FFFF, wRx);
		$display("test receive done");
		apb(1'b1, REG_RATE, 32'h0000_0008);
		apb(1'b1, REG_CTRL, 32'h0000_0165);
		apb(1'b1, REG_TXAPER, 32'h8123_4567);
		waitWord(w, t0);
		chk("aperiodic word", par(32'h8123_4567), w);
		chk("custom pulse", 32'd4, i_ace_line_model.pulseW);
		chk("leg open", 32'h0000_0002, {30'h0, legOpen});
		chk("leg ground", 32'h0000_0001, {30'h0, legGnd});
		$display("test transmit done");
		apb(1'b1, REG_CTRL, 32'h0000_0101);
		// Leg outputs are registered from the control register, one edge after it.
		repeat (2) @(posedge clk_sys);
		chk("legs driven", 32'h0000_0000, {28'h0, legOpen, legGnd});
		apb(1'b1, REG_SLOT_BASE, 32'h0055_AA33);
		// Start the slot from an idle driver so its first word lines up with a tick.
		do begin
			apb(1'b0, REG_STATUS, 32'h0000_0000);
		end while (rdv[ST_TXBUSY]);
		apb(1'b1, REG_SLOT_BASE + 8'h04, 32'h0000_0010);
		waitWord(w, t0);
		chk("slot word", par(32'h0055_AA33), w);
		chk("low speed pulse", TB_LO / 2, i_ace_line_model.pulseW);
		apb(1'b1, REG_TXAPER, 32'h1357_9BDF);
		waitWord(w, t1);
		chk("inserted word", par(32'h1357_9BDF), w);
		waitWord(w, t1);
		chk("slot repeat", par(32'h0055_AA33), w);
		chk("slot interval", 16 * TB_TICK, t1 - t0);
		$display("test schedule done");
		wrap_up();
	end
endmodule
`default_nettype wire
